// ### core/acrrs_sequencer.sv
// Functional notes
// - system clock ratios 128..768 fS; 192 only master quad rate
// - master rate-select codes decode to fixed rate and clock ratio table
// - stream mode allows only code 100 at 384 or 101 at 256
// - slave mode measures clock ratio itself, ignoring rate-select for it
// - slave codes 000 single, 001 dual, 010 quad at 128; rest reserved
// - modulator at 128, 64, 32 fS; stream mode at 64 fS
// - start initialisation when both supply power-good indications are high
// - low reset input starts reset; open input reads low
// - output forced zero in reset and one sample period after release
// - output valid only after 1116 sample periods following release
// - reset low over 65536 sample periods enters power-down
// - power-down count uses system clock, plus frame clock in slave
// - reset high from power-down starts the ordinary release sequence
// - three shared audio pins carry PCM or one-bit stream signals
// - master/slave pin low selects master; slave excludes stream mode
// - both format pins high select stream mode; else PCM formats
module acrrs_sequencer
  import acrrs_pkg::*;
#(
  parameter int unsigned PWRDN_N = PWRDN_PERIODS,
  parameter int unsigned SETTLE_N = SETTLE_PERIODS
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // supplies and reset pin
  input  wire logic       digitalSupplyGood,
  input  wire logic       analogSupplyGood,
  input  wire logic       resetPin_n,
  // configuration pins
  input  wire logic       rate_select_bit0,
  input  wire logic       rate_select_bit1,
  input  wire logic       rate_select_bit2,
  input  wire logic       format_sel0,
  input  wire logic       format_sel1,
  input  wire logic       slaveSelect,
  // frame clock pin, input in slave mode
  input  wire logic       frameClockIn,
  // decoded configuration
  output logic [1:0]      rate_q,
  output logic [9:0]      clockRatio_q,
  output logic [7:0]      modulatorRatio_q,
  output logic            one_bit_stream_mode_q,
  output logic            slaveMode_q,
  output logic            configError_q,
  // sequencing status
  output logic            inReset_q,
  output logic            outputZero_q,
  output logic            outputValid_q,
  output logic            powerDown_q,
  output logic            samplePulse_q
);

  logic [9:0] syncPins;
  logic [2:0] rateSel;
  logic       rstHigh;
  logic       suppliesGood;
  logic       frameLvl;
  logic       frameLvlPrev_q;
  logic       frameEdge;
  logic [9:0] detRatio;
  logic       detLocked;
  logic       streamReq;
  logic       releaseOk;
  logic [9:0] divCnt_q;
  logic [16:0] periodCnt_q;
  logic [9:0] ratioNow;
  logic       tick;
  logic       lastClk;
  acrrs_state_t state_q;

  // pins pass the three-stage synchroniser
  acrrs_sync #(.W(10)) u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .asyncIn ({frameClockIn, slaveSelect, format_sel1, format_sel0,
               rate_select_bit2, rate_select_bit1, rate_select_bit0,
               resetPin_n, analogSupplyGood, digitalSupplyGood}),
    .syncOut (syncPins)
  );

  assign suppliesGood = syncPins[0] & syncPins[1];
  // an open pin is pulled low externally, so it reads as reset
  assign rstHigh      = syncPins[2];
  assign rateSel      = syncPins[5:3];
  assign streamReq    = syncPins[7:6] == FMT_STREAM;
  assign frameLvl     = syncPins[9];
  assign releaseOk    = suppliesGood & rstHigh;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      frameLvlPrev_q <= 1'b0;
    end else begin
      frameLvlPrev_q <= frameLvl;
    end
  end

  // previous level resets low like the idle pin, so no false edge follows reset
  assign frameEdge = frameLvl & ~frameLvlPrev_q;

  acrrs_ratio_detect u_detect (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .frameEdge (frameEdge),
    .ratio_q   (detRatio),
    .locked_q  (detLocked)
  );

  // configuration is latched only while held in reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slaveMode_q           <= 1'b0;
      one_bit_stream_mode_q <= 1'b0;
      rate_q                <= RATE_SINGLE;
      clockRatio_q          <= RATIO_768;
      modulatorRatio_q      <= MOD_SINGLE;
      configError_q         <= 1'b0;
    end else if (state_q == ST_RESET || state_q == ST_PWRDOWN) begin
      slaveMode_q           <= syncPins[8];
      one_bit_stream_mode_q <= streamReq && !syncPins[8];
      configError_q         <= 1'b0;
      if (!syncPins[8]) begin
        unique case (rateSel)
          3'b000: begin
            rate_q <= RATE_SINGLE;
            clockRatio_q <= RATIO_768;
          end
          3'b001: begin
            rate_q <= RATE_SINGLE;
            clockRatio_q <= RATIO_512;
          end
          3'b010: begin
            rate_q <= RATE_SINGLE;
            clockRatio_q <= RATIO_384;
          end
          3'b011: begin
            rate_q <= RATE_SINGLE;
            clockRatio_q <= RATIO_256;
          end
          3'b100: begin
            rate_q <= RATE_DUAL;
            clockRatio_q <= RATIO_384;
          end
          3'b101: begin
            rate_q <= RATE_DUAL;
            clockRatio_q <= RATIO_256;
          end
          3'b110: begin
            rate_q <= RATE_QUAD;
            clockRatio_q <= RATIO_192;
          end
          3'b111: begin
            rate_q <= RATE_QUAD;
            clockRatio_q <= RATIO_128;
          end
        endcase
        // stream mode accepts only codes 100 and 101
        if (streamReq && rateSel[2:1] != 2'b10) begin
          configError_q <= 1'b1;
        end
        if (streamReq || rateSel[2:1] == 2'b10) begin
          modulatorRatio_q <= MOD_DUAL;
        end else if (rateSel[2]) begin
          modulatorRatio_q <= MOD_QUAD;
        end else begin
          modulatorRatio_q <= MOD_SINGLE;
        end
      end else begin
        clockRatio_q <= detRatio;
        unique case (rateSel)
          3'b000: begin
            rate_q <= RATE_SINGLE;
            modulatorRatio_q <= MOD_SINGLE;
          end
          3'b001: begin
            rate_q <= RATE_DUAL;
            modulatorRatio_q <= MOD_DUAL;
          end
          3'b010: begin
            rate_q <= RATE_QUAD;
            modulatorRatio_q <= MOD_QUAD;
            configError_q <= detLocked && detRatio != RATIO_128;
          end
          default: begin
            rate_q <= RATE_SINGLE;
            modulatorRatio_q <= MOD_SINGLE;
            configError_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // live ratio: slave tracks the detector while counting power-down
  assign ratioNow = slaveMode_q ? detRatio : clockRatio_q;

  // last system clock of a sample period, shared by divider and tick
  function automatic logic periodEnd(input logic [9:0] cnt, input logic [9:0] ratio);
    periodEnd = cnt >= ratio - 10'h001;
  endfunction

  assign lastClk = periodEnd(divCnt_q, ratioNow);

  // one sample-period tick per ratio system clocks
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      divCnt_q <= '0;
    end else if (lastClk) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 10'h001;
    end
  end

  // slave mode counts frame clock edges, master mode the divided clock
  assign tick = slaveMode_q ? frameEdge : lastClk;

  // sample-period strobe, one clock wide
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      samplePulse_q <= 1'b0;
    end else begin
      samplePulse_q <= tick;
    end
  end

  // main sequence
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q     <= ST_RESET;
      periodCnt_q <= '0;
    end else if (!releaseOk) begin
      // supply or pin low: hold in reset; pin low with supplies good counts toward power-down
      if (state_q == ST_PWRDOWN) begin
        periodCnt_q <= '0;
      end else if (state_q != ST_RESET) begin
        state_q     <= ST_RESET;
        periodCnt_q <= '0;
      end else if (!rstHigh && suppliesGood && tick) begin
        if (periodCnt_q >= 17'(PWRDN_N)) begin
          state_q     <= ST_PWRDOWN;
          periodCnt_q <= '0;
        end else begin
          periodCnt_q <= periodCnt_q + 17'h00001;
        end
      end
    end else begin
      unique case (state_q)
        ST_RESET, ST_PWRDOWN: begin
          state_q     <= ST_RELEASE;
          periodCnt_q <= '0;
        end
        // one sample period more with the output still forced to zero
        ST_RELEASE: begin
          if (tick) begin
            state_q     <= ST_SETTLE;
            periodCnt_q <= '0;
          end
        end
        // output stays invalid until the settle count is done
        ST_SETTLE: begin
          if (tick) begin
            if (periodCnt_q >= 17'(SETTLE_N - 1)) begin
              state_q     <= ST_RUN;
              periodCnt_q <= '0;
            end else begin
              periodCnt_q <= periodCnt_q + 17'h00001;
            end
          end
        end
        ST_RUN: begin
          // a lost release condition is handled above and returns to reset
          periodCnt_q <= '0;
        end
        // unused state codes fall back to reset
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  // status outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inReset_q     <= 1'b1;
      outputZero_q  <= 1'b1;
      outputValid_q <= 1'b0;
      powerDown_q   <= 1'b0;
    end else begin
      inReset_q     <= state_q == ST_RESET || state_q == ST_PWRDOWN
                       || state_q == ST_RELEASE;
      outputZero_q  <= state_q != ST_SETTLE && state_q != ST_RUN;
      outputValid_q <= state_q == ST_RUN;
      powerDown_q   <= state_q == ST_PWRDOWN;
    end
  end

endmodule

// ### core/acrrs_pkg.sv
package acrrs_pkg;

  // rate families
  typedef enum logic [1:0] {
    RATE_SINGLE = 2'b00,
    RATE_DUAL   = 2'b01,
    RATE_QUAD   = 2'b10
  } acrrs_rate_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_RESET    = 3'b000,
    ST_RELEASE  = 3'b001,
    ST_SETTLE   = 3'b010,
    ST_RUN      = 3'b011,
    ST_PWRDOWN  = 3'b100
  } acrrs_state_t;

  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned RELEASE_PERIODS = 1;
  localparam int unsigned SETTLE_PERIODS  = 1116;
  localparam int unsigned PWRDN_PERIODS   = 65536;

  // system clock ratios, in multiples of fS
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_192 = 10'h0C0;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_384 = 10'h180;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_768 = 10'h300;

  // modulator rates, in multiples of fS
  localparam logic [7:0] MOD_SINGLE = 8'h80;
  localparam logic [7:0] MOD_DUAL   = 8'h40;
  localparam logic [7:0] MOD_QUAD   = 8'h20;

  // format code that selects the one-bit stream
  localparam logic [1:0] FMT_STREAM = 2'b11;

  // slave clock detect: ratio measurement window
  localparam int unsigned DETECT_W = 11;

endpackage

// ### core/acrrs_sync.sv
module acrrs_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      // a bit changes once the second and third stages agree
      for (int i = 0; i < W; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          syncOut[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule

// ### core/acrrs_ratio_detect.sv
module acrrs_ratio_detect
  import acrrs_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // synchronised frame clock edge
  input  wire logic       frameEdge,
  // measured ratio
  output logic      [9:0] ratio_q,
  output logic            locked_q
);

  logic [DETECT_W-1:0] count_q;

  function automatic logic [9:0] snapRatio(input logic [DETECT_W-1:0] n);
    if (n < 11'd160) begin
      snapRatio = RATIO_128;
    end else if (n < 11'd320) begin
      snapRatio = RATIO_256;
    end else if (n < 11'd448) begin
      snapRatio = RATIO_384;
    end else if (n < 11'd640) begin
      snapRatio = RATIO_512;
    end else begin
      snapRatio = RATIO_768;
    end
  endfunction

  // counts system clocks between frame clock rising edges
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_q  <= '0;
      ratio_q  <= RATIO_256;
      locked_q <= 1'b0;
    end else if (frameEdge) begin
      count_q  <= 11'h001;
      if (locked_q || count_q != '0) begin
        ratio_q  <= snapRatio(count_q);
        locked_q <= count_q != '0;
      end
    end else if (count_q != 11'h7FF) begin
      count_q <= count_q + 11'h001;
    end else begin
      locked_q <= 1'b0;
    end
  end

endmodule

// ### dv/acrrs_partner.sv
module acrrs_partner (
  // clock
  input  wire logic       clk_sys,
  // bench requests
  input  wire logic       supplyOn,
  input  wire logic       releaseReq,
  input  wire logic [9:0] frameRatio,
  // pins toward the device
  output logic            digitalSupplyGood,
  output logic            analogSupplyGood,
  output logic            resetPin_n,
  output logic            frameClockIn
);
  timeunit 1ns;
  timeprecision 100ps;
  int clkCount = 0;
  int phase = 0;
  always @(posedge clk_sys) begin
    if (clkCount < 3) begin
      clkCount <= clkCount + 1;
    end
    digitalSupplyGood <= supplyOn && clkCount >= 3;
    analogSupplyGood  <= supplyOn && clkCount >= 3;
    resetPin_n        <= releaseReq && clkCount >= 3;
    // frame clock stands still when unused, else keeps running through power-down
    if (frameRatio == 10'h000) begin
      phase <= 0;
      frameClockIn <= 1'b0;
    end else begin
      phase <= (phase + 1 >= int'(frameRatio)) ? 0 : phase + 1;
      frameClockIn <= phase < int'(frameRatio) / 2;
    end
  end
endmodule

// ### dv/acrrs_chk.sv
module acrrs_chk
  import acrrs_pkg::*;
#(
  parameter int unsigned PWRDN_N  = 8,
  parameter int unsigned SETTLE_N = 4
) (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       digitalSupplyGood,
  input wire logic       analogSupplyGood,
  input wire logic       resetPin_n,
  input wire logic [1:0] rate_q,
  input wire logic [9:0] clockRatio_q,
  input wire logic [7:0] modulatorRatio_q,
  input wire logic       one_bit_stream_mode_q,
  input wire logic       slaveMode_q,
  input wire logic       configError_q,
  input wire logic       inReset_q,
  input wire logic       outputZero_q,
  input wire logic       outputValid_q,
  input wire logic       powerDown_q,
  input wire logic       samplePulse_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_zeroInReset; inReset_q |-> outputZero_q && !outputValid_q; endproperty
  a_zeroInReset: assert property (p_zeroInReset) else $error("output live in reset");
  property p_pinLow; $fell(resetPin_n) |-> ##[1:6] outputZero_q; endproperty
  a_pinLow: assert property (p_pinLow) else $error("reset pin ignored");
  property p_supply; $fell(digitalSupplyGood && analogSupplyGood) |-> ##[1:6] inReset_q;
  endproperty
  a_supply: assert property (p_supply) else $error("supply loss ignored");
  property p_mod;
    outputValid_q |-> modulatorRatio_q == (one_bit_stream_mode_q ? MOD_DUAL :
      rate_q == RATE_DUAL ? MOD_DUAL : rate_q == RATE_QUAD ? MOD_QUAD : MOD_SINGLE);
  endproperty
  a_mod: assert property (p_mod) else $error("modulator ratio wrong");
  property p_ratio192; outputValid_q && clockRatio_q == RATIO_192 |-> !slaveMode_q
    && rate_q == RATE_QUAD; endproperty
  a_ratio192: assert property (p_ratio192) else $error("ratio 192 misused");
  property p_noSlaveStream; one_bit_stream_mode_q |-> !slaveMode_q; endproperty
  a_noSlaveStream: assert property (p_noSlaveStream) else $error("slave stream");
  property p_pdNotValid; powerDown_q |-> !outputValid_q && $past(!resetPin_n, 6); endproperty
  a_pdNotValid: assert property (p_pdNotValid) else $error("power-down misplaced");
  property p_pdExit; powerDown_q && $rose(resetPin_n) && digitalSupplyGood
    && analogSupplyGood |-> ##[1:8] !powerDown_q; endproperty
  a_pdExit: assert property (p_pdExit) else $error("power-down exit late");
  property p_pulse; samplePulse_q |=> !samplePulse_q; endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulse too long");
  c_valid: cover property ($rose(outputValid_q));
  c_pd: cover property ($rose(powerDown_q));
  c_err: cover property ($rose(configError_q));
endmodule
bind acrrs_sequencer acrrs_chk #(.PWRDN_N(PWRDN_N), .SETTLE_N(SETTLE_N)) chk_u (.*);

// ### dv/test_adc_clock_rate_reset_sequencer.sv
module test_adc_clock_rate_reset_sequencer
  import acrrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SETTLE_N = 4;
  localparam int PWRDN_N = 8;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic supplyOn = 1'b1;
  logic releaseReq = 1'b0;
  logic [9:0] frameRatio = 10'h000;
  logic rate_select_bit0 = 1'b0, rate_select_bit1 = 1'b0, rate_select_bit2 = 1'b0;
  logic format_sel0 = 1'b0, format_sel1 = 1'b0, slaveSelect = 1'b0;
  logic digitalSupplyGood, analogSupplyGood, resetPin_n, frameClockIn;
  logic [1:0] rate_q;
  logic [9:0] clockRatio_q;
  logic [7:0] modulatorRatio_q;
  logic one_bit_stream_mode_q, slaveMode_q, configError_q, inReset_q;
  logic outputZero_q, outputValid_q, powerDown_q, samplePulse_q;
  int errors = 0;
  int n_compared = 0;
  logic [9:0] mTab [8] = '{RATIO_768, RATIO_512, RATIO_384, RATIO_256,
                           RATIO_384, RATIO_256, RATIO_192, RATIO_128};
  acrrs_sequencer #(.PWRDN_N(PWRDN_N), .SETTLE_N(SETTLE_N)) dut_u (.*);
  acrrs_partner partner_u (.*);
  always #12.5 clk_sys = ~clk_sys;
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // pins change only while reset is held low
  task automatic configure(logic [2:0] code, logic [1:0] fmt, logic slv, logic [9:0] fr);
    @(posedge clk_sys);
    #1 releaseReq = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 {rate_select_bit2, rate_select_bit1, rate_select_bit0} = code;
    {format_sel1, format_sel0} = fmt;
    slaveSelect = slv;
    frameRatio = fr;
    // long enough for the slave ratio detector to see two frame edges
    repeat (20 + 3 * int'(fr)) @(posedge clk_sys);
    #1 releaseReq = 1'b1;
  endtask
  task automatic runUp(logic [9:0] ratio);
    int n;
    n = 0;
    while (outputZero_q !== 1'b0 && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    check("release", 16'(n <= int'(ratio) + 12), 16'h0001);
    n = 0;
    while (outputValid_q !== 1'b1 && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    check("settle", 16'((n + int'(ratio) / 2) / int'(ratio)), 16'(SETTLE_N));
    #1;
  endtask
  initial begin
    int k;
    repeat (20) @(posedge clk_sys);
    #1 srst = 1'b0;
    for (int c = 0; c < 8; c++) begin
      configure(3'(c), 2'b00, 1'b0, 10'h000);
      runUp(mTab[c]);
      check("ratio", 16'(clockRatio_q), 16'(mTab[c]));
      check("rate", 16'(rate_q), c < 4 ? 16'(RATE_SINGLE) : c < 6 ? 16'(RATE_DUAL)
            : 16'(RATE_QUAD));
      check("mod", 16'(modulatorRatio_q), c < 4 ? 16'(MOD_SINGLE) : c < 6 ? 16'(MOD_DUAL)
            : 16'(MOD_QUAD));
      check("pd", 16'(powerDown_q), 16'h0000);
    end
    for (int c = 4; c < 6; c++) begin
      configure(3'(c), 2'b11, 1'b0, 10'h000);
      runUp(mTab[c]);
      check("stream", 16'(one_bit_stream_mode_q), 16'h0001);
      check("smod", 16'(modulatorRatio_q), 16'(MOD_DUAL));
      check("sratio", 16'(clockRatio_q), 16'(mTab[c]));
    end
    configure(3'h0, 2'b11, 1'b0, 10'h000);
    repeat (10) @(posedge clk_sys);
    #1 check("streamErr", 16'(configError_q), 16'h0001);
    for (int c = 0; c < 3; c++) begin
      configure(3'(c), 2'b00, 1'b1, c == 0 ? RATIO_512 : c == 1 ? RATIO_256 : RATIO_128);
      runUp(frameRatio);
      check("detect", 16'(clockRatio_q), 16'(frameRatio));
      check("srate", 16'(rate_q), 16'(c));
      check("slave", 16'(slaveMode_q), 16'h0001);
    end
    configure(3'h1, 2'b11, 1'b1, RATIO_256);
    runUp(RATIO_256);
    check("slaveStream", 16'(one_bit_stream_mode_q), 16'h0000);
    for (int c = 3; c < 8; c++) begin
      configure(3'(c), 2'b00, 1'b1, RATIO_256);
      repeat (10) @(posedge clk_sys);
      #1 check("reserved", 16'(configError_q), 16'h0001);
    end
    configure(3'h3, 2'b00, 1'b0, 10'h000);
    runUp(RATIO_256);
    releaseReq = 1'b0;
    repeat (PWRDN_N * 256 - 100) @(posedge clk_sys);
    #1 check("pdEarly", 16'(powerDown_q), 16'h0000);
    repeat (400) @(posedge clk_sys);
    #1 check("pd", 16'(powerDown_q), 16'h0001);
    releaseReq = 1'b1;
    runUp(RATIO_256);
    check("pdExit", 16'(powerDown_q), 16'h0000);
    check("runReset", 16'(inReset_q), 16'h0000);
    k = 0;
    repeat (1024) begin
      @(posedge clk_sys);
      k += int'(samplePulse_q);
    end
    check("pulses", 16'(k), 16'(1024 / int'(RATIO_256)));
    #1 supplyOn = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 check("supplyZero", 16'(outputZero_q), 16'h0001);
    check("supplyReset", 16'(inReset_q), 16'h0001);
    supplyOn = 1'b1;
    runUp(RATIO_256);
    final_report();
  end
  initial begin
    #2_500_000;
    errors++;
    final_report();
  end
endmodule
